// ==== hw/epst_consts.svh ====
/*
 * Timing constants for the energy pulse and serial entry block.
 * Assumes the system clock is the master clock: one clock per period.
 */
`ifndef EPST_CONSTS_SVH
`define EPST_CONSTS_SVH

// ----------------------------------------------------------------------
// clock relation
// ----------------------------------------------------------------------
`define EPST_CLK_PER_MCLK     1

// ----------------------------------------------------------------------
// pulse timing, in master clock periods
// ----------------------------------------------------------------------
`define EPST_DR_MCLK          4
`define EPST_RATE_MCLK        256
`define EPST_FW_MCLK          984376
`define EPST_HW_MCLK          322160
`define EPST_HW_FIX_MCLK      64
`define EPST_WIN_END_MCLK     32
`define EPST_WIN_START_MCLK   1

// ----------------------------------------------------------------------
// derived cycle counts
// ----------------------------------------------------------------------
`define EPST_DR_CYC     (`EPST_DR_MCLK * `EPST_CLK_PER_MCLK)
`define EPST_RATE_CYC   (`EPST_RATE_MCLK * `EPST_CLK_PER_MCLK)
`define EPST_FW_CYC     (`EPST_FW_MCLK * `EPST_CLK_PER_MCLK)
`define EPST_HW_CYC     (`EPST_HW_MCLK * `EPST_CLK_PER_MCLK)
`define EPST_FIX_CYC    (`EPST_HW_FIX_MCLK * `EPST_CLK_PER_MCLK)
`define EPST_WIN_CYC    (`EPST_WIN_END_MCLK * `EPST_CLK_PER_MCLK)

// ----------------------------------------------------------------------
// serial entry code and frequency select values
// ----------------------------------------------------------------------
`define EPST_CODE_BITS  8
`define EPST_ENTRY_CODE 8'hA4
`define EPST_FSEL_FIXED 3'h3
`define EPST_SYNC_LAT   3

`endif

// ==== hw/epst_pkg.sv ====
/*
 * Types shared by the energy pulse and serial entry block.
 * Assumes nothing of its surroundings.
 */
package epst_pkg;
	typedef logic [20:0] epst_cnt_t;
	typedef logic [7:0]  epst_code_t;
	typedef enum logic [1:0] {
		EPST_W_FULL,
		EPST_W_HALF,
		EPST_W_FIXED
	} epst_wmode_t;
endpackage

// ==== hw/epst_pulse_gen.sv ====
/*
 * One pulse output: fixed width, half of the measured period, or a
 * fixed short width. Assumes triggers are one-cycle strobes on sys_clk_i.
 */
`timescale 1ns/1ps
`include "epst_consts.svh"

module epst_pulse_gen #(
	parameter int unsigned W_CYC   = `EPST_HW_CYC,
	parameter int unsigned FIX_CYC = `EPST_FIX_CYC,
	parameter bit          ACT_LOW = 1'b0
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// control
	input  wire logic clear_i,
	input  wire logic trig_i,
	input  wire logic fixed_i,
	// pulse pin
	output logic      pulse_o
);
	localparam epst_pkg::epst_cnt_t WC = epst_pkg::epst_cnt_t'(W_CYC);
	localparam epst_pkg::epst_cnt_t FC = epst_pkg::epst_cnt_t'(FIX_CYC);
	localparam epst_pkg::epst_cnt_t W2 = epst_pkg::epst_cnt_t'(2 * W_CYC);

	epst_pkg::epst_cnt_t   per_q;
	epst_pkg::epst_cnt_t   cnt_q;
	epst_pkg::epst_cnt_t   cnt_d;
	epst_pkg::epst_cnt_t   width;
	epst_pkg::epst_wmode_t mode;
	logic                  pulse_q;

	// width choice from the period just measured
	always_comb begin
		if (fixed_i) begin
			mode  = epst_pkg::EPST_W_FIXED;
			width = FC;
		end else if (per_q < W2) begin
			mode  = epst_pkg::EPST_W_HALF;
			width = (per_q > 21'h000001) ? (per_q >> 1) : 21'h000001;
		end else begin
			mode  = epst_pkg::EPST_W_FULL;
			width = WC;
		end
	end

	// period measurement, saturating so the first pulse is full width
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			per_q <= 21'h1FFFFF;
		end else if (clear_i) begin
			per_q <= 21'h1FFFFF;
		end else if (trig_i) begin
			per_q <= 21'h000001;
		end else if (per_q != 21'h1FFFFF) begin
			per_q <= per_q + 21'h000001;
		end
	end

	// width down-counter; a new trigger restarts the pulse
	always_comb begin
		if (clear_i) begin
			cnt_d = '0;
		end else if (trig_i) begin
			cnt_d = width;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 21'h000001;
		end else begin
			cnt_d = '0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q   <= '0;
			pulse_q <= ACT_LOW;
		end else begin
			cnt_q   <= cnt_d;
			pulse_q <= (cnt_d != '0) ^ ACT_LOW;
		end
	end

	assign pulse_o = pulse_q;

	// ------------------------------------------------------------------
	// checks: run length matches the width chosen at the trigger
	// ------------------------------------------------------------------
	epst_pkg::epst_cnt_t   run_q;
	epst_pkg::epst_cnt_t   exp_q;
	epst_pkg::epst_wmode_t mode_q;

	// helper: length of the current active run
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_q  <= '0;
			exp_q  <= '0;
			mode_q <= epst_pkg::EPST_W_FULL;
		end else if (trig_i && !clear_i) begin
			run_q  <= 21'h000001;
			exp_q  <= width;
			mode_q <= mode;
		end else if (cnt_q != '0) begin
			run_q  <= run_q + 21'h000001;
		end
	end

	a_full_len: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(cnt_q == 21'h000001 && !trig_i && !clear_i &&
		 mode_q == epst_pkg::EPST_W_FULL) |-> (run_q == WC))
		else $error("full pulse width wrong");

	a_half_len: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(cnt_q == 21'h000001 && !trig_i && !clear_i &&
		 mode_q == epst_pkg::EPST_W_HALF) |-> (run_q == exp_q))
		else $error("half period width wrong");

	a_fixed_len: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(cnt_q == 21'h000001 && !trig_i && !clear_i &&
		 mode_q == epst_pkg::EPST_W_FIXED) |-> (run_q == FC))
		else $error("fixed pulse width wrong");
endmodule

// ==== hw/epst_top.sv ====
/*
 * Energy pulse outputs, data-ready strobe and serial mode entry.
 * Assumes sys_clk_i is the master clock and link_sck_i is the serial
 * clock pin (the same pin as frequency select bit 2).
 */
`timescale 1ns/1ps
`include "epst_consts.svh"

// Overview of operation
// - in serial mode, data-ready strobe lasts four master clock periods per new output set.
// - counter pulse low width is half the period when period is short.
// - calibration pulse width is half the period when period is short.
// - select code 0,1,1 fixes calibration pulse width at 64 periods.
// - otherwise counter outputs stay low for 984376 periods per pulse.
// - otherwise calibration pulse lasts 322160 periods.
// - master clear low resets logic; its release arms serial mode entry.
module epst_top #(
	parameter int unsigned FW_CYCLES = `EPST_FW_CYC,
	parameter int unsigned HW_CYCLES = `EPST_HW_CYC
) (
	// system clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// serial link clock (pin shared with frequency select bit 2)
	input  wire logic link_sck_i,
	// pins
	input  wire logic master_clear_n_i,
	input  wire logic freq_select_bit0_i,
	input  wire logic freq_select_bit1_i,
	// energy engine strobes, same clock
	input  wire logic counter_trig_i,
	input  wire logic cal_trig_i,
	input  wire logic neg_detect_i,
	// outputs
	output logic      counter_pulse_a_o,
	output logic      counter_pulse_b_o,
	output logic      calibration_pulse_out_o,
	output logic      negative_power_flag_o,
	output logic      serial_mode_o,
	output logic      data_ready_o
);
	localparam logic [5:0] WIN_LAST =
		6'(`EPST_WIN_CYC + `EPST_SYNC_LAT);
	localparam logic [7:0] RATE_LAST = 8'(`EPST_RATE_CYC - 1);
	localparam logic [2:0] DR_LAST   = 3'(`EPST_DR_CYC - 1);

	// ------------------------------------------------------------------
	// link domain: shift in entry code bits
	// ------------------------------------------------------------------
	epst_pkg::epst_code_t sh_q;
	epst_pkg::epst_code_t code_q;
	logic [2:0]           bit_q;
	logic                 code_tgl_q;

	// bits are shifted while chip select (bit 0 pin) is low
	always_ff @(posedge link_sck_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sh_q       <= '0;
			code_q     <= '0;
			bit_q      <= '0;
			code_tgl_q <= 1'b0;
		end else if (freq_select_bit0_i) begin
			bit_q      <= '0;
		end else begin
			sh_q  <= {sh_q[6:0], freq_select_bit1_i};
			bit_q <= bit_q + 3'h1;
			if (bit_q == 3'h7) begin
				code_q     <= {sh_q[6:0], freq_select_bit1_i};
				code_tgl_q <= ~code_tgl_q;
			end
		end
	end

	// ------------------------------------------------------------------
	// system domain: pin synchronisers
	// ------------------------------------------------------------------
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic       tgl_seen_q;

	// two flops per pin, and for the code toggle
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= 5'h00;
			s2_q <= 5'h00;
		end else begin
			s1_q <= {code_tgl_q, master_clear_n_i, link_sck_i,
			         freq_select_bit1_i, freq_select_bit0_i};
			s2_q <= s1_q;
		end
	end

	logic master_clear_n_s;
	logic code_evt;
	assign master_clear_n_s   = s2_q[3];
	assign code_evt = s2_q[4] ^ tgl_seen_q;

	// ------------------------------------------------------------------
	// master clear, strap capture and entry window
	// ------------------------------------------------------------------
	logic       master_clear_n_q;
	logic [2:0] fsel_q;
	logic [5:0] win_q;
	logic       serial_q;

	// release edge of master clear opens the window
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			master_clear_n_q <= 1'b0;
			win_q  <= '0;
			fsel_q <= '0;
		end else begin
			master_clear_n_q <= master_clear_n_s;
			if (!master_clear_n_s) begin
				win_q <= '0;
			end else if (!master_clear_n_q) begin
				win_q  <= 6'h01;
				fsel_q <= s2_q[2:0];
			end else if (win_q != 6'h3F) begin
				win_q <= win_q + 6'h01;
			end
		end
	end

	// serial mode taken only for a code seen inside the window
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tgl_seen_q <= 1'b0;
			serial_q   <= 1'b0;
		end else begin
			tgl_seen_q <= s2_q[4];
			if (!master_clear_n_s) begin
				serial_q <= 1'b0;
			end else if (code_evt && win_q != '0 && win_q <= WIN_LAST &&
			             code_q == `EPST_ENTRY_CODE) begin
				serial_q <= 1'b1;
			end
		end
	end

	assign serial_mode_o = serial_q;

	// ------------------------------------------------------------------
	// data-ready strobe, once per output word set
	// ------------------------------------------------------------------
	logic [7:0] rate_q;
	logic [2:0] dr_q;
	logic       dr_o_q;

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rate_q <= '0;
			dr_q   <= '0;
			dr_o_q <= 1'b0;
		end else if (!serial_q || !master_clear_n_s) begin
			rate_q <= '0;
			dr_q   <= '0;
			dr_o_q <= 1'b0;
		end else begin
			rate_q <= (rate_q == RATE_LAST) ? 8'h00 : rate_q + 8'h01;
			if (rate_q == RATE_LAST) begin
				dr_q   <= DR_LAST;
				dr_o_q <= 1'b1;
			end else if (dr_q != '0) begin
				dr_q   <= dr_q - 3'h1;
			end else begin
				dr_o_q <= 1'b0;
			end
		end
	end

	assign data_ready_o = dr_o_q;

	// ------------------------------------------------------------------
	// pulse outputs
	// ------------------------------------------------------------------
	logic       sel_q;
	logic [1:0] cnt_pulse;
	logic       fixed;
	assign fixed = (fsel_q == `EPST_FSEL_FIXED);

	// counter triggers alternate between the two counter pins
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sel_q <= 1'b0;
		end else if (!master_clear_n_s) begin
			sel_q <= 1'b0;
		end else if (counter_trig_i) begin
			sel_q <= ~sel_q;
		end
	end

	for (genvar i = 0; i < 2; i++) begin : g_cnt
		epst_pulse_gen #(
			.W_CYC   (FW_CYCLES),
			.FIX_CYC (`EPST_FIX_CYC),
			.ACT_LOW (1'b1)
		) u_cnt (
			.sys_clk_i (sys_clk_i),
			.rstn_i    (rstn_i),
			.clear_i   (!master_clear_n_s),
			.trig_i    (counter_trig_i && (sel_q == 1'(i))),
			.fixed_i   (1'b0),
			.pulse_o   (cnt_pulse[i])
		);
	end

	assign counter_pulse_a_o = cnt_pulse[0];
	assign counter_pulse_b_o = cnt_pulse[1];

	epst_pulse_gen #(
		.W_CYC   (HW_CYCLES),
		.FIX_CYC (`EPST_FIX_CYC),
		.ACT_LOW (1'b0)
	) u_cal (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.clear_i   (!master_clear_n_s),
		.trig_i    (cal_trig_i),
		.fixed_i   (fixed),
		.pulse_o   (calibration_pulse_out_o)
	);

	// negative flag follows the detector at calibration pulse starts
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			negative_power_flag_o <= 1'b0;
		end else if (!master_clear_n_s) begin
			negative_power_flag_o <= 1'b0;
		end else if (cal_trig_i) begin
			negative_power_flag_o <= neg_detect_i;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_ready_width: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i || !serial_q)
		$rose(dr_o_q) |-> dr_o_q [*4] ##1 !dr_o_q)
		else $error("data ready width not four");

	a_clear_holds: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		!master_clear_n_s |=> (!serial_q && win_q == '0 && !dr_o_q))
		else $error("master clear did not reset");

	a_window_origin: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i || !master_clear_n_s)
		(master_clear_n_s && !master_clear_n_q) |=> (win_q == 6'h01) ##31 (win_q == 6'h20))
		else $error("entry window not counted from release");

	a_late_refused: assert property (
		@(posedge sys_clk_i) disable iff (!rstn_i)
		(master_clear_n_s && !serial_q && (win_q > WIN_LAST || win_q == '0))
			|=> !serial_q)
		else $error("late entry code accepted");
endmodule

// ==== hw/epst_top_dummy_guard.sv ====
/*
 * Intentionally empty companion file kept minimal.
 * Assumes nothing.
 */

// ==== testbench/epst_host_model.sv ====
/*
 * Host side model: straps on the shared pins and serial entry frames.
 * Assumes the bench sets code and half period before raising go_i.
 */
`timescale 1ns/1ps

module epst_host_model (
	// control from bench
	input  wire logic       go_i,
	input  wire logic [7:0] code_i,
	input  wire logic [7:0] half_ns_i,
	// idle strap levels {bit2, bit1, bit0}
	input  wire logic [2:0] strap_i,
	// shared pins
	output wire logic       sck_o,
	output wire logic       cs_n_o,
	output wire logic       sdi_o,
	output wire logic       busy_o
);
	logic f_sck = 1'h0;
	logic f_sdi = 1'h0;
	logic busy_q = 1'h0;

	// ------------------------------------------------------------------
	// pins
	// ------------------------------------------------------------------
	// straps stand outside frames, so sck stands still between them
	assign busy_o = busy_q;
	assign sck_o  = busy_q ? f_sck : strap_i[2];
	assign sdi_o  = busy_q ? f_sdi : strap_i[1];
	assign cs_n_o = busy_q ? 1'h0 : strap_i[0];

	// one frame, msb first, data changed while sck is low
	always @(posedge go_i) begin
		busy_q = 1'h1;
		f_sck = 1'h0;
		#(half_ns_i);
		for (int i = 7; i >= 0; i--) begin
			f_sdi = code_i[i];
			#(half_ns_i);
			f_sck = 1'h1;
			#(half_ns_i);
			f_sck = 1'h0;
		end
		#(half_ns_i);
		busy_q = 1'h0;
	end
endmodule

// ==== testbench/epst_top_tb_top.sv ====
/*
 * Testbench for epst_top: pulse widths, data-ready strobe, serial entry.
 * Assumes short full widths by parameter and the host model on the pins.
 */
`timescale 1ns/1ps

module epst_top_tb_top;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	localparam int FW = 40;
	localparam int HW = 20;
	logic       sys_clk_i = 1'h0;
	logic       rstn_i = 1'h0;
	logic       master_clear_n_i = 1'h0;
	logic       counter_trig_i = 1'h0;
	logic       cal_trig_i = 1'h0;
	logic       neg_detect_i = 1'h0;
	logic       go = 1'h0;
	logic [7:0] code = 8'h00;
	logic [7:0] half_ns = 8'h0F;
	logic [2:0] strap = 3'h1;
	wire logic  sck, cs_n, sdi, busy;
	logic       pa, pb, pcal, nflag, smode, drdy;
	int         n_mismatch = 0;
	int         num_checks = 0;
	int         cnt [4] = '{default: 0};
	int         base [4];

	// 200 MHz clock
	always #2.5 sys_clk_i = ~sys_clk_i;

	epst_top #(.FW_CYCLES(FW), .HW_CYCLES(HW)) u_epst_top (
		.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .link_sck_i(sck),
		.master_clear_n_i(master_clear_n_i),
		.freq_select_bit0_i(cs_n), .freq_select_bit1_i(sdi),
		.counter_trig_i(counter_trig_i), .cal_trig_i(cal_trig_i),
		.neg_detect_i(neg_detect_i), .counter_pulse_a_o(pa),
		.counter_pulse_b_o(pb), .calibration_pulse_out_o(pcal),
		.negative_power_flag_o(nflag), .serial_mode_o(smode),
		.data_ready_o(drdy));

	epst_host_model u_epst_host_model (
		.go_i(go), .code_i(code), .half_ns_i(half_ns), .strap_i(strap),
		.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .busy_o(busy));

	// active cycles seen on the two counter outputs, the calibration output and data ready
	always @(posedge sys_clk_i) begin
		cnt[0] <= cnt[0] + int'(pa === 1'h0);
		cnt[1] <= cnt[1] + int'(pb === 1'h0);
		cnt[2] <= cnt[2] + int'(pcal === 1'h1);
		cnt[3] <= cnt[3] + int'(drdy === 1'h1);
	end

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0d seen %0d", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	function automatic logic [31:0] dlt(input int k);
		return cnt[k] - base[k];
	endfunction

	task automatic trig(input bit cal);
		@(negedge sys_clk_i);
		if (cal) begin
			cal_trig_i = 1'h1;
		end else begin
			counter_trig_i = 1'h1;
		end
		@(negedge sys_clk_i);
		cal_trig_i = 1'h0;
		counter_trig_i = 1'h0;
	endtask

	task automatic mclear(input int after);
		@(negedge sys_clk_i);
		master_clear_n_i = 1'h0;
		cyc(10);
		master_clear_n_i = 1'h1;
		cyc(after);
	endtask

	task automatic send(input logic [7:0] c, input logic [7:0] h);
		int k = 0;
		code = c;
		half_ns = h;
		@(negedge sys_clk_i);
		go = 1'h1;
		@(negedge sys_clk_i);
		go = 1'h0;
		while (busy === 1'h1 && k < 100) begin
			cyc(1);
			k++;
		end
		cyc(8);
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_counter();
		base = cnt;
		trig(1'h0);
		cyc(8);
		trig(1'h0);
		cyc(48);
		check("counter a full", dlt(0), FW);
		check("counter b full", dlt(1), FW);
		base = cnt;
		trig(1'h0);
		cyc(80);
		check("counter a half", dlt(0), 30);
		check("counter b idle", dlt(1), 0);
	endtask

	task automatic t_cal();
		base = cnt;
		trig(1'h1);
		cyc(28);
		check("cal full", dlt(2), HW);
		neg_detect_i = 1'h1;
		base = cnt;
		trig(1'h1);
		cyc(28);
		check("cal half", dlt(2), 15);
		check("neg flag", nflag, 1'h1);
	endtask

	task automatic t_fixed();
		strap = 3'h3;
		mclear(6);
		base = cnt;
		trig(1'h1);
		cyc(90);
		check("cal fixed", dlt(2), 64);
		strap = 3'h1;
	endtask

	// 30 ns frames cannot fit the window, so the accepted one runs faster
	task automatic t_entry();
		int k = 0;
		mclear(2);
		send(8'hA4, 8'h07);
		check("entry accepted", smode, 1'h1);
		while (drdy !== 1'h1 && k < 300) begin
			cyc(1);
			k++;
		end
		base = cnt;
		cyc(255);
		check("ready gap", drdy, 1'h0);
		cyc(1);
		check("ready next", drdy, 1'h1);
		check("ready width", dlt(3), 4);
		mclear(4);
		check("mode cleared", smode, 1'h0);
		send(8'hA4, 8'h0F);
		check("slow code", smode, 1'h0);
		mclear(60);
		send(8'hA4, 8'h07);
		check("late code", smode, 1'h0);
	endtask

	// ------------------------------------------------------------------
	// run
	// ------------------------------------------------------------------
	task automatic conclude();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		cyc(10);
		rstn_i = 1'h1;
		cyc(2);
		master_clear_n_i = 1'h1;
		cyc(6);
		t_counter();
		t_cal();
		t_fixed();
		t_entry();
		conclude();
	end

	// watchdog
	initial begin
		#100000;
		n_mismatch++;
		conclude();
	end
endmodule
